// File: rtl/pdcc_pkg.sv
// Constants, field layout and helpers for the pin driver/compare control block
package pdcc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CH0_CFG_OFS = 8'h04;
  localparam logic [7:0] CH1_CFG_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] TRIM_OFS_OFS = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_PAR_BIT = 0;
  localparam int CTRL_DIFF_BIT = 1;
  localparam int CFG_TRIM_LSB = 0;
  localparam int CFG_INV_BIT = 4;
  localparam int CFG_TERM_BIT = 5;
  localparam int CFG_W = 6;

  // ----------------------------------------
  // Reset values and trim scale
  // ----------------------------------------
  localparam logic [3:0] TRIM_RESET = 4'h8;
  localparam logic [15:0] TRIM_NOMINAL = 16'h0008;
  localparam logic [15:0] TRIM_STEP_MOHM = 16'h0168;
  localparam logic [CFG_W-1:0] CFG_RESET = {2'b00, TRIM_RESET};
  localparam logic [1:0] CTRL_RESET = 2'b00;

  // ----------------------------------------
  // Driver output selection, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    PDCC_DRV_LOW  = 4'b0001,
    PDCC_DRV_HIGH = 4'b0010,
    PDCC_DRV_TERM = 4'b0100,
    PDCC_DRV_HIZ  = 4'b1000
  } pdcc_drv_type;

  // Signed offset in milliohm, two's complement, for a trim code
  function automatic logic [15:0] pdcc_trim_mohm(input logic [3:0] code);
    logic [31:0] prod;
    prod = 32'({12'h000, code} - TRIM_NOMINAL) * 32'(TRIM_STEP_MOHM);
    return prod[15:0];
  endfunction

endpackage

// File: rtl/pdcc_drive_channel.sv
// One channel of drive data steering, inversion and output selection
`timescale 1ns/10ps
module pdcc_drive_channel
  import pdcc_pkg::*;
(
  // Data sources
  input wire logic own_data_p,
  input wire logic own_data_n,
  input wire logic ch0_data_p,
  input wire logic ch0_data_n,
  input wire logic receive_select_input,
  // Settings
  input wire logic parallel_drive_select,
  input wire logic invert,
  input wire logic termination_select,
  // Driver controls
  output pdcc_drv_type drv_mode,
  output logic clamp_en
);

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  // In parallel drive both channels follow the channel 0 pair
  wire logic sel_p = parallel_drive_select ? ch0_data_p : own_data_p;
  wire logic sel_n = parallel_drive_select ? ch0_data_n : own_data_n;
  // Inverting swaps the pair; per-channel so parallel mode can be complementary
  wire logic pair_p = invert ? sel_n : sel_p;
  wire logic pair_n = invert ? sel_p : sel_n;
  // Both legs decide: the bit is high only while the p leg is high and the n leg is low
  wire logic data_bit = pair_p & ~pair_n;

  // ----------------------------------------
  // Output selection
  // ----------------------------------------
  always_comb begin
    if (!receive_select_input) begin
      drv_mode = data_bit ? PDCC_DRV_HIGH : PDCC_DRV_LOW;
    end else begin
      drv_mode = termination_select ? PDCC_DRV_TERM : PDCC_DRV_HIZ;
    end
  end

  // Clamps only ever act while receiving in high impedance
  assign clamp_en = (drv_mode == PDCC_DRV_HIZ);

endmodule

// File: rtl/pdcc_compare_route.sv
// Comparator result routing between window and differential modes
`timescale 1ns/10ps
module pdcc_compare_route (
  // Mode
  input wire logic diff_compare_select,
  // Per-channel window comparator inputs
  input wire logic [1:0] high_compare_in,
  input wire logic [1:0] low_compare_in,
  // Differential comparator inputs
  input wire logic diff_high_in,
  input wire logic diff_low_in,
  // Routed results
  output logic [1:0] high_compare_result,
  output logic [1:0] low_compare_result
);

  // ----------------------------------------
  // Routing
  // ----------------------------------------
  // Purely combinational so results keep the analog edge timing
  always_comb begin
    if (diff_compare_select) begin
      high_compare_result = {1'b1, diff_high_in};
      low_compare_result = {1'b1, diff_low_in};
    end else begin
      high_compare_result = high_compare_in;
      low_compare_result = low_compare_in;
    end
  end

endmodule

// File: rtl/pdcc_top.sv
// Pin driver and comparator control with its AHB-Lite register slave
`timescale 1ns/10ps
module pdcc_top
  import pdcc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Formatter inputs
  input wire logic [1:0] drive_data_p,
  input wire logic [1:0] drive_data_n,
  input wire logic [1:0] receive_select_input,
  // Analog comparator crossings
  input wire logic [1:0] high_compare_in,
  input wire logic [1:0] low_compare_in,
  input wire logic diff_high_in,
  input wire logic diff_low_in,
  // Driver controls
  output pdcc_drv_type drv_mode0,
  output pdcc_drv_type drv_mode1,
  output logic [1:0] clamp_en,
  output logic [3:0] output_resistance_trim0,
  output logic [3:0] output_resistance_trim1,
  // Comparator results
  output logic [1:0] high_compare_result,
  output logic [1:0] low_compare_result
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [CFG_W-1:0] ch0_cfg_r;
  logic [CFG_W-1:0] ch0_cfg_nxt;
  logic [CFG_W-1:0] ch1_cfg_r;
  logic [CFG_W-1:0] ch1_cfg_nxt;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [3:0] trim0_r;
  logic [3:0] trim1_r;
  logic [3:0] cmp_s1_r;
  logic [3:0] cmp_s2_r;
  logic [3:0] cmp_s3_r;
  logic [3:0] cmp_stable_r;
  logic [3:0] cmp_raw;
  pdcc_drv_type mode0;
  pdcc_drv_type mode1;
  logic [1:0] clamp;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Only NONSEQ and SEQ carry a transfer; BUSY and IDLE are dropped
  wire logic addr_phase = hsel & htrans[1] & hready;
  wire logic wr_take = addr_phase & hwrite;
  wire logic rd_take = addr_phase & ~hwrite;
  wire logic [7:0] word_addr = {haddr[7:2], 2'b00};
  wire logic addr_in_map = (haddr[31:8] == 24'h00_0000);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  wire logic wr_ctrl = wr_pend_r & hit(wr_addr_r, CTRL_OFS);
  wire logic wr_ch0 = wr_pend_r & hit(wr_addr_r, CH0_CFG_OFS);
  wire logic wr_ch1 = wr_pend_r & hit(wr_addr_r, CH1_CFG_OFS);

  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  // A write lands in its data phase, when hwdata is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_take & addr_in_map;
      wr_addr_r <= word_addr;
    end
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  assign ctrl_nxt = wr_ctrl ? hwdata[1:0] : ctrl_r;
  assign ch0_cfg_nxt = wr_ch0 ? hwdata[CFG_W-1:0] : ch0_cfg_r;
  assign ch1_cfg_nxt = wr_ch1 ? hwdata[CFG_W-1:0] : ch1_cfg_r;

  // All settings clear on reset; trim returns to the nominal code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      ch0_cfg_r <= CFG_RESET;
      ch1_cfg_r <= CFG_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      ch0_cfg_r <= ch0_cfg_nxt;
      ch1_cfg_r <= ch1_cfg_nxt;
    end
  end

  wire logic parallel_drive_select = ctrl_r[CTRL_PAR_BIT];
  wire logic diff_compare_select = ctrl_r[CTRL_DIFF_BIT];
  wire logic [3:0] ch0_trim = ch0_cfg_r[CFG_TRIM_LSB +: 4];
  wire logic [3:0] ch1_trim = ch1_cfg_r[CFG_TRIM_LSB +: 4];

  // ----------------------------------------
  // Trim outputs
  // ----------------------------------------
  // Registered copy keeps the analog trim lines glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim0_r <= TRIM_RESET;
      trim1_r <= TRIM_RESET;
    end else begin
      trim0_r <= ch0_cfg_nxt[CFG_TRIM_LSB +: 4];
      trim1_r <= ch1_cfg_nxt[CFG_TRIM_LSB +: 4];
    end
  end

  assign output_resistance_trim0 = trim0_r;
  assign output_resistance_trim1 = trim1_r;

  // ----------------------------------------
  // Drive channels
  // ----------------------------------------
  pdcc_drive_channel u_drv0 (
    .own_data_p(drive_data_p[0]),
    .own_data_n(drive_data_n[0]),
    .ch0_data_p(drive_data_p[0]),
    .ch0_data_n(drive_data_n[0]),
    .receive_select_input(receive_select_input[0]),
    .parallel_drive_select(parallel_drive_select),
    .invert(ch0_cfg_r[CFG_INV_BIT]),
    .termination_select(ch0_cfg_r[CFG_TERM_BIT]),
    .drv_mode(mode0),
    .clamp_en(clamp[0])
  );

  pdcc_drive_channel u_drv1 (
    .own_data_p(drive_data_p[1]),
    .own_data_n(drive_data_n[1]),
    .ch0_data_p(drive_data_p[0]),
    .ch0_data_n(drive_data_n[0]),
    .receive_select_input(receive_select_input[1]),
    .parallel_drive_select(parallel_drive_select),
    .invert(ch1_cfg_r[CFG_INV_BIT]),
    .termination_select(ch1_cfg_r[CFG_TERM_BIT]),
    .drv_mode(mode1),
    .clamp_en(clamp[1])
  );

  // Drive path stays combinational: a clock stage would skew pin timing
  assign drv_mode0 = mode0;
  assign drv_mode1 = mode1;
  assign clamp_en = clamp;

  // ----------------------------------------
  // Comparator routing
  // ----------------------------------------
  // Each channel brings its own high and low crossing bits
  pdcc_compare_route u_cmp (
    .diff_compare_select(diff_compare_select),
    .high_compare_in(high_compare_in),
    .low_compare_in(low_compare_in),
    .diff_high_in(diff_high_in),
    .diff_low_in(diff_low_in),
    .high_compare_result(high_compare_result),
    .low_compare_result(low_compare_result)
  );

  // ----------------------------------------
  // Status synchroniser
  // ----------------------------------------
  // Software sees the routed results; they are async to hclk
  assign cmp_raw = {low_compare_result[1], high_compare_result[1],
                    low_compare_result[0], high_compare_result[0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_r <= 4'h0;
      cmp_s2_r <= 4'h0;
      cmp_s3_r <= 4'h0;
      cmp_stable_r <= 4'h0;
    end else begin
      cmp_s1_r <= cmp_raw;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      for (int i = 0; i < 4; i++) begin
        if (cmp_s2_r[i] == cmp_s3_r[i]) begin
          cmp_stable_r[i] <= cmp_s3_r[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Uses next values so a read right after a write sees the new data
  wire logic [31:0] rd_ctrl = {30'h0000_0000, ctrl_nxt};
  wire logic [31:0] rd_ch0 = {26'h000_0000, ch0_cfg_nxt};
  wire logic [31:0] rd_ch1 = {26'h000_0000, ch1_cfg_nxt};
  wire logic [31:0] rd_status = {18'h0_0000, clamp, mode1, mode0, cmp_stable_r};
  wire logic [31:0] rd_trim = {pdcc_trim_mohm(ch1_cfg_nxt[CFG_TRIM_LSB +: 4]),
                               pdcc_trim_mohm(ch0_cfg_nxt[CFG_TRIM_LSB +: 4])};

  // Unmapped addresses read zero and still answer OKAY
  wire logic [31:0] rd_mux =
    !addr_in_map ? 32'h0000_0000 :
    hit(word_addr, CTRL_OFS) ? rd_ctrl :
    hit(word_addr, CH0_CFG_OFS) ? rd_ch0 :
    hit(word_addr, CH1_CFG_OFS) ? rd_ch1 :
    hit(word_addr, STATUS_OFS) ? rd_status :
    hit(word_addr, TRIM_OFS_OFS) ? rd_trim : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_r <= rd_mux;
    end
  end

  // Zero wait states; a new read is captured each address phase
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // hsize is accepted but only whole-word access is meaningful here
  wire logic unused_size = ^hsize;

endmodule

// File: sim/pdcc_monitor.sv
// Port checker of the pin driver/compare control block
`timescale 1ns/10ps
module pdcc_monitor
  import pdcc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // Formatter and crossings
  input wire logic [1:0] drive_data_p,
  input wire logic [1:0] drive_data_n,
  input wire logic [1:0] receive_select_input,
  input wire logic [1:0] high_compare_in,
  input wire logic [1:0] low_compare_in,
  input wire logic diff_high_in,
  input wire logic diff_low_in,
  // Outputs
  input pdcc_drv_type drv_mode0,
  input pdcc_drv_type drv_mode1,
  input wire logic [1:0] clamp_en,
  input wire logic [3:0] output_resistance_trim0,
  input wire logic [3:0] output_resistance_trim1,
  input wire logic [1:0] high_compare_result,
  input wire logic [1:0] low_compare_result
);
  // ----------------------------------------
  // Settings mirrored from observed writes
  // ----------------------------------------
  logic aw_r;
  logic [7:0] aa_r;
  logic [1:0] ctl_r;
  logic [5:0] c0_r, c1_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_r <= 1'b0;
      aa_r <= 8'h00;
      ctl_r <= CTRL_RESET;
      c0_r <= CFG_RESET;
      c1_r <= CFG_RESET;
    end else begin
      aw_r <= hsel && htrans[1] && hwrite && (haddr[31:8] == 24'h00_0000);
      aa_r <= haddr[7:0];
      if (aw_r && aa_r == CTRL_OFS) ctl_r <= hwdata[1:0];
      if (aw_r && aa_r == CH0_CFG_OFS) c0_r <= hwdata[5:0];
      if (aw_r && aa_r == CH1_CFG_OFS) c1_r <= hwdata[5:0];
    end
  end
  // Equal p and n reads as 0, so a swap alone is enough for inversion
  wire logic b0 = c0_r[CFG_INV_BIT] ? drive_data_n[0] & ~drive_data_p[0] : drive_data_p[0] & ~drive_data_n[0];
  wire logic [1:0] s1 = ctl_r[CTRL_PAR_BIT] ? {drive_data_p[0], drive_data_n[0]} : {drive_data_p[1], drive_data_n[1]};
  wire logic b1 = c1_r[CFG_INV_BIT] ? s1[0] & ~s1[1] : s1[1] & ~s1[0];
  function automatic pdcc_drv_type emode(logic r, logic t, logic b);
    return r ? (t ? PDCC_DRV_TERM : PDCC_DRV_HIZ) : (b ? PDCC_DRV_HIGH : PDCC_DRV_LOW);
  endfunction
  sequence wr_s(logic [7:0] a);
    hsel && htrans[1] && hwrite && haddr == {24'h00_0000, a} ##1 1'b1;
  endsequence
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  trim_reset_a: assert property ($rose(hresetn) |-> output_resistance_trim0 == TRIM_RESET && output_resistance_trim1 == TRIM_RESET)
    else $error("trim not at reset code");
  trim_write_a: assert property (wr_s(CH1_CFG_OFS) |=> output_resistance_trim1 == $past(hwdata[3:0]))
    else $error("trim did not take written code");
  trim_hold_a: assert property (!(aw_r && aa_r == CH0_CFG_OFS) |=> $stable(output_resistance_trim0))
    else $error("trim changed without a write");
  drive_ch0_a: assert property (drv_mode0 == emode(receive_select_input[0], c0_r[CFG_TERM_BIT], b0))
    else $error("channel 0 driver mode wrong");
  drive_ch1_a: assert property (drv_mode1 == emode(receive_select_input[1], c1_r[CFG_TERM_BIT], b1))
    else $error("channel 1 driver mode wrong");
  clamp_hiz_a: assert property (clamp_en == {drv_mode1 == PDCC_DRV_HIZ, drv_mode0 == PDCC_DRV_HIZ})
    else $error("clamp enable not tied to high impedance");
  window_pass_a: assert property (!ctl_r[CTRL_DIFF_BIT] |-> {high_compare_result, low_compare_result} == {high_compare_in, low_compare_in})
    else $error("window results not passed through");
  diff_route_a: assert property (ctl_r[CTRL_DIFF_BIT] |-> {high_compare_result[0], low_compare_result[0]} == {diff_high_in, diff_low_in})
    else $error("differential results not on channel 0");
  ch1_forced_a: assert property (ctl_r[CTRL_DIFF_BIT] |-> high_compare_result[1] && low_compare_result[1])
    else $error("channel 1 results not forced high");
endmodule
bind pdcc_top pdcc_monitor i_pdcc_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .drive_data_p(drive_data_p), .drive_data_n(drive_data_n),
  .receive_select_input(receive_select_input), .high_compare_in(high_compare_in), .low_compare_in(low_compare_in),
  .diff_high_in(diff_high_in), .diff_low_in(diff_low_in), .drv_mode0(drv_mode0), .drv_mode1(drv_mode1),
  .clamp_en(clamp_en), .output_resistance_trim0(output_resistance_trim0),
  .output_resistance_trim1(output_resistance_trim1), .high_compare_result(high_compare_result),
  .low_compare_result(low_compare_result));

// File: sim/pdcc_formatter_model.sv
// Formatter model launching drive data pairs and receive selects
`timescale 1ns/10ps
module pdcc_formatter_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench commands
  input wire logic [1:0] bit_cmd,
  input wire logic [1:0] recv_cmd,
  // Formatter outputs
  output logic [1:0] drive_data_p,
  output logic [1:0] drive_data_n,
  output logic [1:0] receive_select_input
);
  // Launched on the clock so pairs never show a skewed half-state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_data_p <= 2'h0;
      drive_data_n <= 2'h3;
      receive_select_input <= 2'h0;
    end else begin
      drive_data_p <= bit_cmd;
      drive_data_n <= ~bit_cmd;
      receive_select_input <= recv_cmd;
    end
  end
endmodule

// File: sim/tb_pin_driver_compare_control.sv
// Self-checking bench of the pin driver/compare control block
`timescale 1ns/10ps
module tb_pin_driver_compare_control
  import pdcc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dhi, dli;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0] hsize;
  logic [1:0] htrans, bit_cmd, recv_cmd, dp, dn, rs, hci, lci, clamp, hcr, lcr;
  logic [3:0] tr0, tr1;
  pdcc_drv_type m0, m1;
  int miscompares, checks_done;
  pdcc_top i_pdcc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .drive_data_p(dp), .drive_data_n(dn), .receive_select_input(rs),
    .high_compare_in(hci), .low_compare_in(lci), .diff_high_in(dhi), .diff_low_in(dli), .drv_mode0(m0),
    .drv_mode1(m1), .clamp_en(clamp), .output_resistance_trim0(tr0), .output_resistance_trim1(tr1),
    .high_compare_result(hcr), .low_compare_result(lcr));
  pdcc_formatter_model i_pdcc_formatter_model (.hclk(hclk), .hresetn(hresetn), .bit_cmd(bit_cmd),
    .recv_cmd(recv_cmd), .drive_data_p(dp), .drive_data_n(dn), .receive_select_input(rs));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(nm, e, rd);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask
  function automatic pdcc_drv_type emode(logic r, logic t, logic b);
    return r ? (t ? PDCC_DRV_TERM : PDCC_DRV_HIZ) : (b ? PDCC_DRV_HIGH : PDCC_DRV_LOW);
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset_vals;
    #1;
    chk("trims", {24'h00_0000, TRIM_RESET, TRIM_RESET}, {24'h00_0000, tr1, tr0});
    rchk("ctrl", CTRL_OFS, 32'h0000_0000);
    rchk("cfg0", CH0_CFG_OFS, 32'h0000_0008);
    rchk("cfg1", CH1_CFG_OFS, 32'h0000_0008);
    rchk("offset", TRIM_OFS_OFS, 32'h0000_0000);
    rchk("unmapped", 8'h14, 32'h0000_0000);
  endtask
  task t_trim;
    for (int c = 0; c < 16; c++) begin
      wr(CH0_CFG_OFS, 32'(c));
      wr(CH1_CFG_OFS, 32'(15 - c));
      rchk("offset", TRIM_OFS_OFS, {16'((7 - c) * 360), 16'((c - 8) * 360)});
      chk("trim0", 32'(c), {28'h000_0000, tr0});
    end
  endtask
  task t_drive;
    logic b0, b1;
    for (int i = 0; i < 8; i++) begin
      wr(CTRL_OFS, {31'h0000_0000, i[2]});
      wr(CH0_CFG_OFS, {26'h000_0000, i[0], i[0], 4'h8});
      wr(CH1_CFG_OFS, {26'h000_0000, i[1], i[1], 4'h8});
      for (int j = 0; j < 16; j++) begin
        @(posedge hclk);
        bit_cmd <= j[1:0];
        recv_cmd <= j[3:2];
        repeat (2) @(posedge hclk);
        #1;
        b0 = j[0] ^ i[0];
        b1 = (i[2] ? j[0] : j[1]) ^ i[1];
        chk("mode0", 32'(emode(j[2], i[0], b0)), 32'(m0));
        chk("mode1", 32'(emode(j[3], i[1], b1)), 32'(m1));
        chk("clamp", {30'h0000_0000, j[3] & ~i[1], j[2] & ~i[0]}, {30'h0000_0000, clamp});
      end
    end
  endtask
  task t_compare;
    logic [3:0] st;
    // Both channels parked in termination so the status word has known driver modes
    @(posedge hclk);
    recv_cmd <= 2'b11;
    wr(CH0_CFG_OFS, 32'h0000_0028);
    wr(CH1_CFG_OFS, 32'h0000_0028);
    for (int d = 0; d < 2; d++) begin
      wr(CTRL_OFS, {30'h0000_0000, d[0], 1'b0});
      for (int j = 0; j < 64; j++) begin
        @(posedge hclk);
        {dhi, dli, hci, lci} <= j[5:0];
        @(posedge hclk);
        #1;
        chk("high", d ? {30'h0, 1'b1, j[5]} : {30'h0, j[3:2]}, {30'h0, hcr});
        chk("low", d ? {30'h0, 1'b1, j[4]} : {30'h0, j[1:0]}, {30'h0, lcr});
        // Status goes through the synchroniser, so give it time to settle
        repeat (3) @(posedge hclk);
        st = d ? {2'b11, j[4], j[5]} : {j[1], j[3], j[0], j[2]};
        rchk("status", STATUS_OFS, {18'h0_0000, 2'b00, PDCC_DRV_TERM, PDCC_DRV_TERM, st});
      end
    end
  endtask
  task t_midreset;
    wr(CTRL_OFS, 32'h0000_0003);
    wr(CH0_CFG_OFS, 32'h0000_003F);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_vals();
  endtask
  task complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial begin
    {hresetn, hsel, hwrite, dhi, dli} = 5'h00;
    {haddr, hwdata} = 64'h0;
    hsize = 3'b010;
    {htrans, bit_cmd, recv_cmd, hci, lci} = 10'h000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_vals();
    t_trim();
    t_drive();
    t_compare();
    t_midreset();
    complete_run();
  end
endmodule
